// file: logic/plg_consts.vh
// Constants for the partition label generator
`ifndef PLG_CONSTS_VH
`define PLG_CONSTS_VH
`define PLG_PART_W 16
`define PLG_GRP_W 8
`define PLG_DEF_PART 16'h0000
`define PLG_DEF_GRP 8'h00
`define PLG_MAP_REGS 8
`define PLG_MAP_IDX_W 3
`define PLG_MAP_W 64
`define PLG_ENTRIES_PER_REG 4
// Label register field layout (64-bit)
`define PLG_F_PART_D_LSB 0
`define PLG_F_PART_I_LSB 16
`define PLG_F_GRP_D_LSB 32
`define PLG_F_GRP_I_LSB 40
`endif

// file: logic/plg_map_sel.v
// Mapping register selector and field extractor for virtual identifier translation
`include "plg_consts.vh"
module plg_map_sel (
    input wire [511:0] map_regs_i,
    input wire [15:0] virt_i,
    output wire [15:0] phys_o
);
    reg [63:0] word;
    reg [15:0] field;
    always @*
    begin
        word = 64'h0000000000000000;
        field = 16'h0000;
        // Register index is virt/4; index above the last register reads zero
        if (virt_i[15:2] < `PLG_MAP_REGS)
        begin
            word = map_regs_i[virt_i[4:2]*64 +: 64];
        end
        field = word[virt_i[1:0]*16 +: 16];
    end
    assign phys_o = field;
endmodule // plg_map_sel

// file: logic/plg_label_gen.v
// Partition identifier and monitoring group label generator
`include "plg_consts.vh"
module plg_label_gen (
    input wire mclk_i,
    input wire rst_n_i,
    input wire req_valid_i,
    input wire [1:0] level_sel_i,
    input wire instr_side_select_i,
    input wire level2_active_i,
    input wire [63:0] level3_label_reg_i,
    input wire [63:0] level2_label_reg_i,
    input wire [63:0] level1_label_reg_i,
    input wire [63:0] level0_label_reg_i,
    input wire [3:0] level_virtual_en_i,
    input wire [511:0] virtual_map_regs_i,
    input wire [31:0] virtual_map_valid_reg_i,
    input wire [2:0] max_map_reg_index_i,
    input wire [15:0] max_partition_ident_i,
    input wire [7:0] max_monitor_group_i,
    input wire err_forces_default_grp_i,
    output reg label_valid_o,
    output reg [15:0] partition_ident_o,
    output reg [7:0] monitor_group_o,
    output reg ident_error_o
);
    reg [63:0] lvl_reg;
    reg [15:0] raw_part;
    reg [7:0] raw_grp;
    reg [15:0] virt;
    reg [15:0] mapped;
    reg map_err;
    reg [15:0] next_part;
    reg [7:0] next_grp;
    reg next_err;
    wire [15:0] map_field;

    // Label register of the requested level; an inactive level 2 reads as zeros
    function [63:0] level_word;
        input [1:0] sel;
        input l2_on;
        input [63:0] r3;
        input [63:0] r2;
        input [63:0] r1;
        input [63:0] r0;
        begin
            // Two-bit selector covers all of 0..3, so no unspecified case arises
            case (sel)
                2'h3: level_word = r3;
                2'h2: level_word = l2_on ? r2 : 64'h0000000000000000;
                2'h1: level_word = r1;
                2'h0: level_word = r0;
                default: level_word = 64'h0000000000000000;
            endcase
        end
    endfunction

    // Instruction fetches use the instruction-side field of the word
    function [15:0] pick_ident;
        input [63:0] word;
        input instr;
        begin
            if (instr)
            begin
                pick_ident = word[`PLG_F_PART_I_LSB +: `PLG_PART_W];
            end
            else
            begin
                pick_ident = word[`PLG_F_PART_D_LSB +: `PLG_PART_W];
            end
        end
    endfunction

    // Group fields sit above both identifier fields
    function [7:0] pick_group;
        input [63:0] word;
        input instr;
        begin
            if (instr)
            begin
                pick_group = word[`PLG_F_GRP_I_LSB +: `PLG_GRP_W];
            end
            else
            begin
                pick_group = word[`PLG_F_GRP_D_LSB +: `PLG_GRP_W];
            end
        end
    endfunction

    // Shared by both identifier checks and the group check, so all compare alike
    function over_limit;
        input [15:0] val;
        input [15:0] lim;
        begin
            over_limit = (val > lim);
        end
    endfunction

    // Values beyond the table alias back into it; modulo was chosen over
    // clamping so that every virtual value still reaches a real entry
    function [15:0] reduce_virt;
        input [15:0] raw;
        input [2:0] top_idx;
        reg [15:0] vmax;
        begin
            vmax = {11'h000, top_idx, 2'h3};
            reduce_virt = raw;
            if (raw > vmax)
            begin
                reduce_virt = raw % (vmax + 16'h0001);
            end
        end
    endfunction

    plg_map_sel u_map (
        .map_regs_i(virtual_map_regs_i),
        .virt_i(virt),
        .phys_o(map_field)
    );

    // Both fields come from one word so identifier and group stay paired
    always @*
    begin
        lvl_reg = level_word(level_sel_i, level2_active_i, level3_label_reg_i, level2_label_reg_i,
                             level1_label_reg_i, level0_label_reg_i);
        raw_part = pick_ident(lvl_reg, instr_side_select_i);
        raw_grp = pick_group(lvl_reg, instr_side_select_i);
    end

    // Reduced value never exceeds 31, so five bits index the valid flags
    always @*
    begin
        virt = reduce_virt(raw_part, max_map_reg_index_i);
        mapped = `PLG_DEF_PART;
        map_err = 1'b0;
        if (virtual_map_valid_reg_i[virt[4:0]])
        begin
            mapped = map_field;
        end
        else if (virtual_map_valid_reg_i[0])
        begin
            mapped = virtual_map_regs_i[15:0];
        end
        else
        begin
            map_err = 1'b1;
        end
        if (over_limit(mapped, max_partition_ident_i))
        begin
            mapped = `PLG_DEF_PART;
            map_err = 1'b1;
        end
    end

    // Range check comes first: an out-of-range value never reaches the table
    always @*
    begin
        next_part = raw_part;
        next_err = 1'b0;
        if (over_limit(raw_part, max_partition_ident_i))
        begin
            next_part = `PLG_DEF_PART;
            next_err = 1'b1;
        end
        else if (level_virtual_en_i[level_sel_i])
        begin
            next_part = mapped;
            next_err = map_err;
        end
    end

    // Either group choice on error is allowed; a pin picks which one
    always @*
    begin
        next_grp = raw_grp;
        if (next_err && err_forces_default_grp_i)
        begin
            next_grp = `PLG_DEF_GRP;
        end
        else if (over_limit({8'h00, raw_grp}, {8'h00, max_monitor_group_i}))
        begin
            next_grp = `PLG_DEF_GRP;
        end
    end

    // All three labels are captured in the same edge as the request
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            label_valid_o <= 1'b0;
            partition_ident_o <= `PLG_DEF_PART;
            monitor_group_o <= `PLG_DEF_GRP;
            ident_error_o <= 1'b0;
        end
        else
        begin
            label_valid_o <= req_valid_i;
            if (req_valid_i)
            begin
                partition_ident_o <= next_part;
                monitor_group_o <= next_grp;
                ident_error_o <= next_err;
            end
        end
    end
endmodule // plg_label_gen

// file: bench/plg_label_chk.sv
// Port checker for the label generator
module plg_label_chk (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire logic err_forces_default_grp_i,
    input wire logic [15:0] max_partition_ident_i,
    input wire logic [7:0] max_monitor_group_i,
    input wire logic label_valid_o,
    input wire logic [15:0] partition_ident_o,
    input wire logic [7:0] monitor_group_o,
    input wire logic ident_error_o
);
    timeunit 1ns / 1ps;
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    chk_valid_follow: assert property (req_valid_i |=> label_valid_o) else $error("no label");
    chk_valid_alone: assert property (!req_valid_i |=> !label_valid_o) else $error("extra label");
    chk_ident_hold: assert property (!req_valid_i |=> $stable(partition_ident_o)) else $error("id moved");
    chk_group_hold: assert property (!req_valid_i |=> $stable({monitor_group_o, ident_error_o}))
        else $error("group moved");
    chk_err_default: assert property (ident_error_o |-> partition_ident_o == 16'h0000) else $error("err id");
    chk_ident_max: assert property (label_valid_o |-> partition_ident_o <= $past(max_partition_ident_i))
        else $error("id max");
    chk_group_max: assert property (label_valid_o |-> monitor_group_o <= $past(max_monitor_group_i))
        else $error("grp max");
    chk_err_group: assert property (req_valid_i && err_forces_default_grp_i |=> !ident_error_o
        || monitor_group_o == 8'h00) else $error("err grp");
endmodule // plg_label_chk

// file: bench/plg_sink.sv
// Downstream receiver counting delivered labels
module plg_sink (
    input wire logic mclk_i,
    input wire logic label_valid_i,
    output int labels_seen_o
);
    timeunit 1ns / 1ps;
    int count = 0;
    assign labels_seen_o = count;
    always @(posedge mclk_i)
        if (label_valid_i)
            count <= count + 1;
endmodule // plg_sink

// file: bench/tb_plg_label_gen.sv
// Self-checking bench for the label generator
module tb_plg_label_gen;
    timeunit 1ns / 1ps;
    logic mclk_i = 1'b0, rst_n = 1'b0, req = 1'b0, ins = 1'b0, l2on = 1'b1, efd = 1'b1, lv, err;
    logic [1:0] lvl = 2'h0;
    logic [63:0] lr [4];
    logic [3:0] ven = 4'h0;
    logic [511:0] map = '0;
    logic [31:0] vld = 32'h0;
    logic [2:0] mmax = 3'h1;
    logic [15:0] pmax = 16'h0010;
    logic [7:0] gmax = 8'h08;
    logic [15:0] id;
    logic [7:0] grp;
    int nseen, nreq = 0, num_errors = 0, num_checks = 0;
    always #25 mclk_i = ~mclk_i;
    plg_label_gen i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n), .req_valid_i(req), .level_sel_i(lvl),
        .instr_side_select_i(ins), .level2_active_i(l2on), .level3_label_reg_i(lr[3]),
        .level2_label_reg_i(lr[2]), .level1_label_reg_i(lr[1]), .level0_label_reg_i(lr[0]),
        .level_virtual_en_i(ven), .virtual_map_regs_i(map), .virtual_map_valid_reg_i(vld),
        .max_map_reg_index_i(mmax), .max_partition_ident_i(pmax), .max_monitor_group_i(gmax),
        .err_forces_default_grp_i(efd), .label_valid_o(lv), .partition_ident_o(id),
        .monitor_group_o(grp), .ident_error_o(err));
    plg_sink i_sink (.mclk_i(mclk_i), .label_valid_i(lv), .labels_seen_o(nseen));
    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Request is left high after each call, so calls with no req drop between them run back to back
    task automatic go(logic [1:0] l, logic i, logic [15:0] eid, logic ee, logic [7:0] eg);
        lvl = l;
        ins = i;
        req = 1'b1;
        nreq++;
        @(posedge mclk_i);
        #1;
        chk("valid", 16'(lv), 16'h1);
        chk("ident", id, eid);
        chk("error", 16'(err), 16'(ee));
        chk("group", 16'(grp), 16'(eg));
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #20000;
        num_errors++;
        final_report;
    end
    initial
    begin
        for (int n = 0; n < 4; n++)
            lr[n] = {16'h0, 8'(n + 4), 8'(n), 16'(2 * n + 1), 16'(2 * n)};
        repeat (3) @(posedge mclk_i);
        #1 rst_n = 1'b1;
        for (int n = 0; n < 8; n++)
            go(n[2:1], n[0], 16'(n), 1'b0, 8'(n[2:1] + 4 * n[0]));
        l2on = 1'b0;
        go(2'h2, 1'b1, 16'h0, 1'b0, 8'h00);
        lr[1][15:0] = 16'h0011;
        go(2'h1, 1'b0, 16'h0, 1'b1, 8'h00);
        efd = 1'b0;
        go(2'h1, 1'b0, 16'h0, 1'b1, 8'h01);
        lr[3][39:32] = 8'h09;
        go(2'h3, 1'b0, 16'h6, 1'b0, 8'h00);
        ven = 4'h1;
        vld = 32'h43;
        map[111:96] = 16'h000C;
        map[31:0] = 32'h0003000A;
        lr[0][15:0] = 16'h0006;
        go(2'h0, 1'b0, 16'h000C, 1'b0, 8'h00);
        lr[0][15:0] = 16'h0005;
        go(2'h0, 1'b0, 16'h000A, 1'b0, 8'h00);
        lr[0][15:0] = 16'h0009;
        go(2'h0, 1'b0, 16'h0003, 1'b0, 8'h00);
        lr[0][15:0] = 16'h0006;
        map[111:96] = 16'h0020;
        go(2'h0, 1'b0, 16'h0, 1'b1, 8'h00);
        vld = 32'h0;
        go(2'h0, 1'b0, 16'h0, 1'b1, 8'h00);
        req = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        chk("hold", {lv, err, id[13:0]}, 16'h4000);
        chk("sink", 16'(nseen), 16'(nreq));
        mmax = 3'h0;
        vld = 32'h4;
        map[47:32] = 16'h0005;
        go(2'h0, 1'b0, 16'h0005, 1'b0, 8'h00);
        go(2'h3, 1'b1, 16'h0007, 1'b0, 8'h07);
        req = 1'b0;
        rst_n = 1'b0;
        @(posedge mclk_i);
        #1;
        chk("reset valid", 16'(lv), 16'h0);
        chk("reset ident", id, 16'h0);
        chk("reset err grp", {7'h00, err, grp}, 16'h0);
        rst_n = 1'b1;
        go(2'h3, 1'b0, 16'h0006, 1'b0, 8'h00);
        gmax = 8'h09;
        go(2'h3, 1'b0, 16'h0006, 1'b0, 8'h09);
        pmax = 16'h0011;
        go(2'h1, 1'b0, 16'h0011, 1'b0, 8'h01);
        final_report;
    end
endmodule // tb_plg_label_gen
bind plg_label_gen plg_label_chk i_chk (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i),
    .err_forces_default_grp_i(err_forces_default_grp_i),
    .max_partition_ident_i(max_partition_ident_i),
    .max_monitor_group_i(max_monitor_group_i),
    .label_valid_o(label_valid_o),
    .partition_ident_o(partition_ident_o),
    .monitor_group_o(monitor_group_o),
    .ident_error_o(ident_error_o)
);
